// ---- rtl/milgc_pkg.sv ----
// constants and types for the manual input and light gun capture block
// Contract
// - action button or trigger sets completion indicator
// - gun pulses on first flash of target
// - gun pulse strobes target id to drum
// - transfer started: beam off, rear indicator on
// - trigger release returns gun to idle, beam restored
// - discriminator transfers unmasked targets for one cycle
// - discriminator drops targets in masked regions
// - matrix read only on program read request
package milgc_pkg;
  localparam int unsigned MILGC_NUM_KBD = 4;
  localparam int unsigned MILGC_MSG_W = 16;
  localparam int unsigned MILGC_ID_W = 16;
  localparam int unsigned MILGC_SYNC_STAGES = 3;
  localparam logic MILGC_LAMP_RST = 1'b0;
  localparam logic MILGC_BEAM_RST = 1'b1;
  typedef enum logic [1:0] {
    MILGC_GUN_IDLE = 2'b00,
    MILGC_GUN_ARMED = 2'b01,
    MILGC_GUN_XFER = 2'b10
  } milgc_gun_t;
  typedef enum logic [1:0] {
    MILGC_AD_IDLE = 2'b00,
    MILGC_AD_WAIT = 2'b01,
    MILGC_AD_RUN = 2'b10
  } milgc_ad_t;
endpackage : milgc_pkg

// ---- rtl/milgc_pin_if.sv ----
// interface carrying raw console pins into the pin synchroniser
`timescale 1ns/1ps
interface milgc_pin_if #(
  parameter int unsigned W = 1
);
  logic [W-1:0] raw;
  logic [W-1:0] clean;
  logic [W-1:0] rise;
  logic [W-1:0] fall;
  modport sync (input raw, output clean, output rise, output fall);
  modport user (output raw, input clean, input rise, input fall);
endinterface : milgc_pin_if

// ---- rtl/milgc_sync.sv ----
// three-stage pin synchroniser with edge detection
`timescale 1ns/1ps
module milgc_sync
  import milgc_pkg::*;
#(
  parameter int unsigned W = 1
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_srst,
  // pins
  milgc_pin_if.sync pins
);
  logic [W-1:0] s1_r, s2_r, s3_r, clean_r, rise_r, fall_r;
  logic [W-1:0] s1_nxt, s2_nxt, s3_nxt, clean_nxt, rise_nxt, fall_nxt;
  always_comb begin
    s1_nxt = pins.raw;
    s2_nxt = s1_r;
    s3_nxt = s2_r;
    // change counts only once stages two and three agree
    clean_nxt = clean_r;
    for (int i = 0; i < int'(W); i++) begin
      if (s2_r[i] == s3_r[i]) begin
        clean_nxt[i] = s3_r[i];
      end
    end
    rise_nxt = clean_nxt & ~clean_r;
    fall_nxt = ~clean_nxt & clean_r;
  end
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      clean_r <= '0;
      rise_r <= '0;
      fall_r <= '0;
    end else begin
      s1_r <= s1_nxt;
      s2_r <= s2_nxt;
      s3_r <= s3_nxt;
      clean_r <= clean_nxt;
      rise_r <= rise_nxt;
      fall_r <= fall_nxt;
    end
  end
  assign pins.clean = clean_r;
  assign pins.rise = rise_r;
  assign pins.fall = fall_r;
endmodule : milgc_sync

// ---- rtl/milgc_top.sv ----
// manual input matrix, light gun transfer gating and area discriminator
`timescale 1ns/1ps
module milgc_top
  import milgc_pkg::*;
#(
  parameter int unsigned NUM_KBD = MILGC_NUM_KBD,
  parameter int unsigned MSG_W = MILGC_MSG_W,
  parameter int unsigned ID_W = MILGC_ID_W
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_srst,
  // console pins, asynchronous
  input wire logic [NUM_KBD-1:0] i_action_btn,
  input wire logic [NUM_KBD-1:0] i_gun_trigger,
  input wire logic [NUM_KBD-1:0] i_gun_detect,
  input wire logic i_ad_operate,
  // keyboard selection panels, asynchronous levels
  input wire logic [NUM_KBD*MSG_W-1:0] i_kbd_msg,
  // situation display generator, core clock
  input wire logic [ID_W-1:0] i_situation_display_generator_id,
  input wire logic i_sdg_cycle_start,
  input wire logic i_sdg_target_valid,
  input wire logic i_sdg_target_masked,
  input wire logic i_ad_detect,
  // program read of the manual input matrix
  input wire logic i_mim_rd_req,
  input wire logic [$clog2(NUM_KBD > 1 ? NUM_KBD : 2)-1:0] i_mim_rd_sel,
  output logic o_mim_rd_valid,
  output logic [MSG_W-1:0] o_mim_rd_msg,
  output logic o_mim_rd_complete,
  // manual input drum write
  output logic o_drum_wr,
  output logic [ID_W-1:0] o_drum_id,
  output logic o_drum_from_ad,
  // gun lamps and area discriminator busy
  output logic [NUM_KBD-1:0] o_gun_beam_on,
  output logic [NUM_KBD-1:0] o_gun_rear_ind,
  output logic o_ad_busy
);
  localparam int unsigned PW = 3 * NUM_KBD + 1;
  localparam int unsigned SW = $clog2(NUM_KBD > 1 ? NUM_KBD : 2);

  milgc_pin_if #(.W(PW)) pin_bus ();
  milgc_pin_if #(.W(NUM_KBD*MSG_W)) msg_bus ();
  assign pin_bus.raw = {i_ad_operate, i_gun_detect, i_gun_trigger, i_action_btn};
  assign msg_bus.raw = i_kbd_msg;

  milgc_sync #(.W(PW)) u_pin_sync (
    .i_core_clk(i_core_clk),
    .i_srst(i_srst),
    .pins(pin_bus.sync)
  );
  milgc_sync #(.W(NUM_KBD*MSG_W)) u_msg_sync (
    .i_core_clk(i_core_clk),
    .i_srst(i_srst),
    .pins(msg_bus.sync)
  );

  logic [NUM_KBD-1:0] btn_rise, trig_rise, trig_fall, det_rise;
  assign btn_rise = pin_bus.rise[NUM_KBD-1:0];
  assign trig_rise = pin_bus.rise[2*NUM_KBD-1:NUM_KBD];
  assign trig_fall = pin_bus.fall[2*NUM_KBD-1:NUM_KBD];
  assign det_rise = pin_bus.rise[3*NUM_KBD-1:2*NUM_KBD];
  logic ad_go;
  assign ad_go = pin_bus.rise[PW-1];

  // completion matrix and read port
  logic [NUM_KBD-1:0] done_r, done_nxt;
  logic rd_valid_r, rd_valid_nxt, rd_cmp_r, rd_cmp_nxt;
  logic [MSG_W-1:0] rd_msg_r, rd_msg_nxt;
  always_comb begin
    done_nxt = done_r;
    rd_valid_nxt = 1'b0;
    rd_msg_nxt = rd_msg_r;
    rd_cmp_nxt = rd_cmp_r;
    if (i_mim_rd_req) begin
      rd_valid_nxt = 1'b1;
      rd_msg_nxt = msg_bus.clean[i_mim_rd_sel*MSG_W +: MSG_W];
      rd_cmp_nxt = done_r[i_mim_rd_sel];
      done_nxt[i_mim_rd_sel] = 1'b0;
    end
    // a completion arriving with the read survives it
    done_nxt = done_nxt | btn_rise | trig_rise;
  end
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      done_r <= '0;
      rd_valid_r <= 1'b0;
      rd_msg_r <= '0;
      rd_cmp_r <= 1'b0;
    end else begin
      done_r <= done_nxt;
      rd_valid_r <= rd_valid_nxt;
      rd_msg_r <= rd_msg_nxt;
      rd_cmp_r <= rd_cmp_nxt;
    end
  end

  // light gun per console
  milgc_gun_t gun_r [NUM_KBD];
  milgc_gun_t gun_nxt [NUM_KBD];
  logic [NUM_KBD-1:0] gun_fire, beam_r, beam_nxt, rear_r, rear_nxt;
  always_comb begin
    for (int k = 0; k < int'(NUM_KBD); k++) begin
      gun_nxt[k] = gun_r[k];
      gun_fire[k] = 1'b0;
      unique case (gun_r[k])
        MILGC_GUN_IDLE: begin
          if (trig_rise[k]) begin
            gun_nxt[k] = MILGC_GUN_ARMED;
          end
        end
        MILGC_GUN_ARMED: begin
          if (trig_fall[k]) begin
            gun_nxt[k] = MILGC_GUN_IDLE;
          end else if (det_rise[k] && i_sdg_target_valid) begin
            gun_fire[k] = 1'b1;
            gun_nxt[k] = MILGC_GUN_XFER;
          end
        end
        MILGC_GUN_XFER: begin
          if (trig_fall[k]) begin
            gun_nxt[k] = MILGC_GUN_IDLE;
          end
        end
        default: gun_nxt[k] = MILGC_GUN_IDLE;
      endcase
      beam_nxt[k] = (gun_nxt[k] != MILGC_GUN_XFER);
      rear_nxt[k] = (gun_nxt[k] == MILGC_GUN_XFER);
    end
  end
  always_ff @(posedge i_core_clk) begin
    for (int k = 0; k < int'(NUM_KBD); k++) begin
      if (i_srst) begin
        gun_r[k] <= MILGC_GUN_IDLE;
      end else begin
        gun_r[k] <= gun_nxt[k];
      end
    end
    if (i_srst) begin
      beam_r <= {NUM_KBD{MILGC_BEAM_RST}};
      rear_r <= {NUM_KBD{MILGC_LAMP_RST}};
    end else begin
      beam_r <= beam_nxt;
      rear_r <= rear_nxt;
    end
  end

  // area discriminator: armed, waits for a cycle start, runs one full cycle
  milgc_ad_t ad_r, ad_nxt;
  logic ad_fire;
  always_comb begin
    ad_nxt = ad_r;
    ad_fire = 1'b0;
    unique case (ad_r)
      MILGC_AD_IDLE: begin
        if (ad_go) begin
          ad_nxt = MILGC_AD_WAIT;
        end
      end
      MILGC_AD_WAIT: begin
        if (i_sdg_cycle_start) begin
          ad_nxt = MILGC_AD_RUN;
        end
      end
      MILGC_AD_RUN: begin
        if (i_sdg_cycle_start) begin
          ad_nxt = MILGC_AD_IDLE;
        end else if (i_ad_detect && i_sdg_target_valid && !i_sdg_target_masked) begin
          ad_fire = 1'b1;
        end
      end
      default: ad_nxt = MILGC_AD_IDLE;
    endcase
  end

  // drum write; gun strobes take priority, ad report of same cycle is dropped
  logic drum_wr_r, drum_wr_nxt, from_ad_r, from_ad_nxt;
  logic [ID_W-1:0] drum_id_r, drum_id_nxt;
  always_comb begin
    drum_wr_nxt = 1'b0;
    drum_id_nxt = drum_id_r;
    from_ad_nxt = from_ad_r;
    if (|gun_fire) begin
      drum_wr_nxt = 1'b1;
      drum_id_nxt = i_situation_display_generator_id;
      from_ad_nxt = 1'b0;
    end else if (ad_fire) begin
      drum_wr_nxt = 1'b1;
      drum_id_nxt = i_situation_display_generator_id;
      from_ad_nxt = 1'b1;
    end
  end
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      ad_r <= MILGC_AD_IDLE;
      drum_wr_r <= 1'b0;
      drum_id_r <= '0;
      from_ad_r <= 1'b0;
    end else begin
      ad_r <= ad_nxt;
      drum_wr_r <= drum_wr_nxt;
      drum_id_r <= drum_id_nxt;
      from_ad_r <= from_ad_nxt;
    end
  end

  logic ad_busy_r;
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      ad_busy_r <= 1'b0;
    end else begin
      ad_busy_r <= (ad_nxt != MILGC_AD_IDLE);
    end
  end

  assign o_mim_rd_valid = rd_valid_r;
  assign o_mim_rd_msg = rd_msg_r;
  assign o_mim_rd_complete = rd_cmp_r;
  assign o_drum_wr = drum_wr_r;
  assign o_drum_id = drum_id_r;
  assign o_drum_from_ad = from_ad_r;
  assign o_gun_beam_on = beam_r;
  assign o_gun_rear_ind = rear_r;
  assign o_ad_busy = ad_busy_r;
  logic unused_sel;
  assign unused_sel = ^{SW, pin_bus.clean, pin_bus.fall, msg_bus.rise, msg_bus.fall};
endmodule : milgc_top

// ---- verification/milgc_chk.sv ----
// port assertions for the capture block
`timescale 1ns/1ps
module milgc_chk #(
  parameter int unsigned NUM_KBD = 4
) (
  input wire logic i_core_clk,
  input wire logic i_srst,
  input wire logic i_mim_rd_req,
  input wire logic i_ad_detect,
  input wire logic i_sdg_target_valid,
  input wire logic i_sdg_target_masked,
  input wire logic [NUM_KBD-1:0] i_gun_trigger,
  input wire logic o_mim_rd_valid,
  input wire logic o_drum_wr,
  input wire logic o_drum_from_ad,
  input wire logic o_ad_busy,
  input wire logic [NUM_KBD-1:0] o_gun_beam_on,
  input wire logic [NUM_KBD-1:0] o_gun_rear_ind
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_srst);
  sequence s_fire;
    |(o_gun_rear_ind & ~$past(o_gun_rear_ind));
  endsequence
  sequence s_adwr;
    o_drum_wr && o_drum_from_ad;
  endsequence
  rd_answer_a: assert property (i_mim_rd_req |=> o_mim_rd_valid)
    else $error("read not answered");
  rd_only_a: assert property (o_mim_rd_valid |-> $past(i_mim_rd_req))
    else $error("unrequested answer");
  lamp_pair_a: assert property (o_gun_beam_on == ~o_gun_rear_ind)
    else $error("beam and rear lamp disagree");
  xfer_write_a: assert property (s_fire |-> o_drum_wr && !o_drum_from_ad)
    else $error("transfer without drum write");
  gun_valid_a: assert property (o_drum_wr && !o_drum_from_ad |-> $past(i_sdg_target_valid))
    else $error("gun write without target");
  ad_busy_a: assert property (s_adwr |-> $past(o_ad_busy))
    else $error("scan write while idle");
  ad_mask_a: assert property (s_adwr |-> $past(i_ad_detect) && !$past(i_sdg_target_masked))
    else $error("masked target written");
  // every gun, not just one: no gun drops its rear lamp while its trigger is still held
  rear_off_a: assert property (
    (~o_gun_rear_ind & $past(o_gun_rear_ind) & $past(i_gun_trigger, 3)) == '0)
    else $error("rear lamp off with trigger held");
endmodule : milgc_chk
bind milgc_top milgc_chk #(.NUM_KBD(NUM_KBD)) milgc_chk_i (.*);

// ---- verification/milgc_prog_model.sv ----
// program side: issues matrix reads, acts only on complete messages
`timescale 1ns/1ps
module milgc_prog_model (
  // clock
  input wire logic i_core_clk,
  // bench command
  input wire logic i_go,
  input wire logic [1:0] i_sel,
  // read answer
  input wire logic i_rd_valid,
  input wire logic i_rd_complete,
  // read request and action
  output logic o_rd_req = 1'b0,
  output logic [1:0] o_rd_sel = 2'h0,
  output logic o_act = 1'b0
);
  always @(posedge i_core_clk) begin
    o_rd_req <= i_go;
    // idle select inverts every cycle so a stale value is never trusted
    o_rd_sel <= i_go ? i_sel : ~o_rd_sel;
    o_act <= i_rd_valid & i_rd_complete;
  end
endmodule : milgc_prog_model

// ---- verification/tb_milgc_top.sv ----
// self-checking bench for the capture block
`timescale 1ns/1ps
module tb_milgc_top;
  logic clk = 1'b0, rst = 1'b1, ado = 1'b0, cs = 1'b0, tv = 1'b0, tm = 1'b0;
  logic add = 1'b0, go = 1'b0, a, m, req, rv, rc, dw, dfa, busy, act;
  logic [3:0] btn = 4'h0, trg = 4'h0, det = 4'h0, beam, rear;
  logic [63:0] msg = 64'h0;
  logic [15:0] id = 16'h0, v, rmsg, did;
  logic [1:0] sel = 2'h0, rsel;
  logic [16:0] rq[$], dq[$];
  int n_fail = 0, n_checks = 0, n_act = 0;
  milgc_top milgc_top_i (.i_core_clk(clk), .i_srst(rst), .i_action_btn(btn),
    .i_gun_trigger(trg), .i_gun_detect(det), .i_ad_operate(ado), .i_kbd_msg(msg),
    .i_situation_display_generator_id(id), .i_sdg_cycle_start(cs),
    .i_sdg_target_valid(tv), .i_sdg_target_masked(tm), .i_ad_detect(add),
    .i_mim_rd_req(req), .i_mim_rd_sel(rsel), .o_mim_rd_valid(rv), .o_mim_rd_msg(rmsg),
    .o_mim_rd_complete(rc), .o_drum_wr(dw), .o_drum_id(did), .o_drum_from_ad(dfa),
    .o_gun_beam_on(beam), .o_gun_rear_ind(rear), .o_ad_busy(busy));
  milgc_prog_model milgc_prog_model_i (.i_core_clk(clk), .i_go(go), .i_sel(sel),
    .i_rd_valid(rv), .i_rd_complete(rc), .o_rd_req(req), .o_rd_sel(rsel), .o_act(act));
  initial begin
    forever #5 clk = ~clk;
  end
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      n_fail++;
      $display("wrong value %s exp %h seen %h", nm, e, s);
    end
  endtask : chk
  task tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : tally_and_finish
  task rd(input int k, input logic c);
    @(posedge clk);
    go <= 1'b1;
    sel <= k[1:0];
    rq.push_back({c, msg[k*16+:16]});
    @(posedge clk);
    go <= 1'b0;
  endtask : rd
  always @(posedge clk) begin
    if (rv === 1'b1) chk("read", {rc, rmsg}, rq.size() ? rq.pop_front() : 17'h1ffff);
    if (dw === 1'b1) chk("drum", {dfa, did}, dq.size() ? dq.pop_front() : 17'h1ffff);
    if (act === 1'b1) n_act++;
  end
  initial begin
    #20us;
    n_fail++;
    tally_and_finish;
  end
  initial begin
    void'($urandom(32'hbb04));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    msg <= {$urandom, $urandom};
    repeat (6) @(posedge clk);
    for (int k = 0; k < 4; k++) begin
      rd(k, 1'b0);
      if (k[0]) trg[k] <= 1'b1;
      else btn[k] <= 1'b1;
      // pins held 4 cycles, the synchroniser needs at least 2
      repeat (4) @(posedge clk);
      btn <= 4'h0;
      trg <= 4'h0;
      repeat (8) @(posedge clk);
      rd(k, 1'b1);
      rd(k, 1'b0);
    end
    trg[2] <= 1'b1;
    repeat (8) @(posedge clk);
    v = 16'($urandom);
    id <= v;
    tv <= 1'b1;
    det[2] <= 1'b1;
    dq.push_back({1'b0, v});
    repeat (4) @(posedge clk);
    det <= 4'h0;
    repeat (6) @(posedge clk);
    chk("rear", {beam[2], rear[2]}, 2'h1);
    trg <= 4'h0;
    tv <= 1'b0;
    repeat (10) @(posedge clk);
    chk("rear", {beam[2], rear[2]}, 2'h2);
    ado <= 1'b1;
    repeat (4) @(posedge clk);
    ado <= 1'b0;
    repeat (8) @(posedge clk);
    cs <= 1'b1;
    tv <= 1'b1;
    @(posedge clk);
    cs <= 1'b0;
    chk("busy", busy, 1'b1);
    repeat (12) begin
      @(posedge clk);
      v = 16'($urandom);
      a = 1'($urandom);
      m = 1'($urandom);
      id <= v;
      add <= a;
      tm <= m;
      if (a && !m) dq.push_back({1'b1, v});
    end
    @(posedge clk);
    add <= 1'b0;
    cs <= 1'b1;
    @(posedge clk);
    cs <= 1'b0;
    add <= 1'b1;
    tm <= 1'b0;
    // scan is over, this detect must not reach the drum
    repeat (4) @(posedge clk);
    add <= 1'b0;
    chk("busy", busy, 1'b0);
    chk("left", rq.size() + dq.size(), 32'h0);
    // one action per read that found its message complete
    chk("acts", n_act, 32'h4);
    tally_and_finish;
  end
endmodule : tb_milgc_top
